// [dv/cia_ext_model.sv]
`timescale 1ns/10ps
module cia_ext_model import cia_pkg::*; (
    input wire logic aclk,
    input wire logic [W_DATA-1:0] delta,
    output logic [NSLOT-1:0][W_DATA-1:0] word
);
    // Process card lines start low and flip by each delta the bench pulses.
    initial word = '0;
    always @(posedge aclk)
        word[1] <= word[1] ^ delta;
endmodule

// [dv/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
    import cia_pkg::*;
    logic aclk = 1'b0, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic rvalid, rready, sreq, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seed = 32'h9A96;
    logic [1:0] rresp, bresp;
    logic [1:0] expb[$];
    logic [3:0] wstrb = 4'hF;
    logic [W_DATA-1:0] delta;
    logic [NSLOT-1:0][W_DATA-1:0] ext_w;
    logic [NSLOT-1:0] ext_f = '1;
    logic [33:0] expq[$];
    int n_fail = 0, checks_done = 0;
    cia_top cia_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .card_ext_word(ext_w),
        .card_ext_flag(ext_f), .service_request(sreq), .irq(irq));
    cia_ext_model cia_ext_model_inst (.aclk(aclk), .delta(delta), .word(ext_w));
    // Bench clock, 8 ns period.
    initial forever #4 aclk = ~aclk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic xf(input logic w, input logic [7:0] a, input logic [33:0] e);
        if (w) expb.push_back(e[33:32]);
        else expq.push_back(e);
        @(posedge aclk);
        {awaddr, araddr, wdata} <= {a, a, e[31:0]};
        {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
        do @(negedge aclk); while (w ? !(awready && wready) : !arready);
        @(posedge aclk);
        {awvalid, wvalid, arvalid} <= 3'b000;
        do @(negedge aclk); while (w ? !bvalid : !rvalid);
        @(posedge aclk);
        {bready, rready} <= 2'b00;
    endtask
    // Each accepted read beat is compared with the oldest expected note.
    always @(posedge aclk) begin
        if (rvalid && rready)
            chk("read", expq.pop_front(), {rresp, rdata});
        if (bvalid && bready)
            chk("bresp", {32'h0, expb.pop_front()}, {32'h0, bresp});
    end
    task automatic summarize();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog cuts a hang short.
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        summarize();
    end
    // Reset, group arm, flag and poll, interrupt, then recycle and disarm.
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, delta} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        xf(1'b0, OFF_JUMPER, {RESP_OKAY, 32'h0000000F});
        xf(1'b0, 8'hFC, {RESP_SLVERR, 32'h00000000});
        xf(1'b1, 8'hFC, {RESP_SLVERR, 32'h00000000});
        xf(1'b1, OFF_JUMPER, 34'hE);
        xf(1'b1, OFF_REL, 34'h3);
        xf(1'b1, OFF_CTRL, 34'h0A0);
        xf(1'b1, OFF_ADDR, 34'h1000);
        xf(1'b1, OFF_CTRL, 34'h130);
        @(negedge aclk);
        chk("service_request", 34'h0, {33'h0, sreq});
        @(posedge aclk);
        seed = xs(seed);
        delta <= seed[11:0] | 12'h001;
        @(posedge aclk);
        delta <= '0;
        ext_f[0] <= 1'b0;
        repeat (10) @(negedge aclk);
        chk("service_request", 34'h1, {33'h0, sreq});
        xf(1'b0, OFF_RET + 8'h04, {RESP_OKAY, 20'h00008, seed[11:0] | 12'h001});
        xf(1'b0, OFF_RET, {RESP_OKAY, 32'h00008000});
        xf(1'b1, OFF_MASK, 34'h4);
        repeat (2) @(negedge aclk);
        chk("irq", 34'h1, {33'h0, irq});
        xf(1'b1, OFF_STAT, 34'h4);
        repeat (2) @(negedge aclk);
        chk("irq", 34'h0, {33'h0, irq});
        xf(1'b1, OFF_CTRL, 34'h020);
        xf(1'b1, OFF_DATA, {22'h0, seed[11:0] | 12'h001} | 34'h2000);
        xf(1'b1, OFF_DATA, 34'h1000);
        xf(1'b0, OFF_RET + 8'h04, {RESP_OKAY, 32'h00000000});
        xf(1'b0, OFF_RET, {RESP_OKAY, 32'h00000000});
        xf(1'b1, OFF_DATA, 34'h3002);
        repeat (300) @(posedge aclk);
        xf(1'b0, OFF_RET + 8'h08, {RESP_OKAY, 32'h00008000});
        xf(1'b1, OFF_DATA, 34'h2000);
        delta <= 12'h00F;
        @(posedge aclk);
        delta <= '0;
        repeat (10) @(negedge aclk);
        xf(1'b0, OFF_RET + 8'h04, {RESP_OKAY, 32'h00000000});
        xf(1'b1, OFF_SYSCLR, 34'h0);
        xf(1'b0, OFF_CTRL, {RESP_OKAY, 32'h00000000});
        summarize();
    end
endmodule

// [hdl/cia_card.sv]
`timescale 1ns/10ps
module cia_card import cia_pkg::*; #(
    parameter cia_ctype_t CTYPE = CT_DIGITAL
) (
    input wire logic aclk,
    input wire logic aresetn,
    cia_card_if.card cif
);
    cia_cstate_t st_q, st_d;
    logic [W_DATA-1:0] word_q, word_d;
    logic [W_DATA-1:0] aux_q;
    logic [W_DATA-1:0] prev_q;
    logic flag_prev_q;

    // Mode decode and gated strobes seen by this card.
    wire out_mode = cif.system_output_enable & ~cif.input_direction_select & ~cif.timed_handshake_enable;
    wire int_mode = cif.timed_handshake_enable & cif.interrupt_arm_enable;
    wire arm_ind = cif.addr_gate & cif.input_direction_select & ~cif.timed_handshake_enable
        & ~cif.group_arm_jumper;
    wire arm_grp = cif.arm_group & cif.group_arm_jumper & (st_q == CS_DISARMED);
    wire dis_addr = cif.addr_gate & ~cif.input_direction_select & ~cif.timed_handshake_enable
        & ((CTYPE == CT_DIGITAL) | (CTYPE == CT_EVENT));
    wire wr_out = cif.data_gate & out_mode;
    wire [W_DATA-1:0] edges = cif.ext_word ^ prev_q;
    wire rel_hit = (cif.relation == REL_EQ) ? (cif.ext_word == aux_q) :
        (cif.relation == REL_NE) ? (cif.ext_word != aux_q) :
        (cif.relation == REL_GT) ? (cif.ext_word > aux_q) : (cif.ext_word < aux_q);
    wire trip = (CTYPE == CT_DIGITAL) ? (flag_prev_q & ~cif.ext_flag) :
        (CTYPE == CT_PROC) ? (|edges) :
        (CTYPE == CT_TIMER) ? (cif.tick & (aux_q == 12'h001)) :
        (rel_hit & int_mode);
    wire [W_DATA-1:0] cap = (CTYPE == CT_PROC) ? edges : cif.ext_word;

    assign cif.armed = (st_q != CS_DISARMED);
    assign cif.card_completion_flag = (st_q == CS_FLAGGED);
    assign cif.held_word = word_q;

    // Next state: arming, tripping, then output words and disarm strobes.
    always_comb begin
        st_d = st_q;
        word_d = word_q;
        if (arm_ind || arm_grp) begin
            st_d = CS_ARMED;
        end
        case (st_q)
            CS_ARMED: if (trip) begin
                st_d = CS_FLAGGED;
                word_d = cap;
            end
            CS_FLAGGED: if (CTYPE == CT_PROC) begin
                word_d = word_q | edges;
            end
            CS_DISARMED: ;
            default: st_d = CS_DISARMED;
        endcase
        if (wr_out) begin
            case (CTYPE)
                CT_PROC: if (&cif.gate_data) begin
                    word_d = 12'h000;
                    if (st_q == CS_FLAGGED) begin
                        st_d = CS_ARMED;
                    end
                end else if (cif.gate_data == 12'h000) begin
                    st_d = CS_DISARMED;
                end else if (cif.gate_data == word_q) begin
                    st_d = CS_ARMED;
                    word_d = 12'h000;
                end
                CT_TIMER: st_d = (cif.gate_data == 12'h000) ? CS_DISARMED : CS_ARMED;
                CT_EVENT: ;
                default: st_d = CS_DISARMED;
            endcase
        end
        if (dis_addr) begin
            st_d = CS_DISARMED;
        end
    end

    // State, captured word, timer count or reference word, edge history.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= CS_DISARMED;
            word_q <= 12'h000;
            aux_q <= 12'h000;
            prev_q <= 12'h000;
            flag_prev_q <= 1'b0;
        end else begin
            st_q <= st_d;
            word_q <= word_d;
            prev_q <= cif.ext_word;
            flag_prev_q <= cif.ext_flag;
            if (wr_out && (CTYPE == CT_TIMER || CTYPE == CT_EVENT)) begin
                aux_q <= cif.gate_data;
            end else if (CTYPE == CT_TIMER && st_q == CS_ARMED && cif.tick && aux_q != 12'h000) begin
                aux_q <= aux_q - 12'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_grp_arm;
        cif.arm_group && cif.group_arm_jumper && st_q == CS_DISARMED && !dis_addr |=> cif.armed;
    endproperty
    a_grp_arm: assert property (p_grp_arm) else $error("Group arm did not arm the card.");

    property p_proc_disarm;
        CTYPE == CT_PROC && wr_out && cif.gate_data == 12'h000 |=> st_q == CS_DISARMED;
    endproperty
    a_proc_disarm: assert property (p_proc_disarm) else $error("Zero word did not disarm.");

    property p_timer_end;
        CTYPE == CT_TIMER && st_q == CS_ARMED && cif.tick && aux_q == 12'h001 && !wr_out
            && !dis_addr |=> cif.card_completion_flag;
    endproperty
    a_timer_end: assert property (p_timer_end) else $error("Timer did not flag at pulse end.");

    property p_event_drop;
        CTYPE == CT_EVENT && st_q == CS_ARMED && !int_mode |=> st_q != CS_FLAGGED;
    endproperty
    a_event_drop: assert property (p_event_drop) else $error("Event card kept an out-of-mode hit.");

    property p_proc_trip;
        CTYPE == CT_PROC && st_q == CS_ARMED && |edges && !wr_out |=> cif.card_completion_flag;
    endproperty
    a_proc_trip: assert property (p_proc_trip) else $error("Edge did not raise the flag.");

    property p_digital_reset;
        CTYPE == CT_DIGITAL && wr_out |=> !cif.armed;
    endproperty
    a_digital_reset: assert property (p_digital_reset) else $error("Data word did not disarm.");
endmodule

// [hdl/cia_top.sv]
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
// Summary of operation
// - Jumpered cards arm on timed-and-arm control word.
// - No service request without armed card interrupting.
// - Return word flag bit marks an interrupting card.
// - Output-mode gated data word disarms digital input card.
// - Event card drops hits outside interrupt mode.
// - Ones initialize, echo recycles, zeros disarm process card.
// - Any of twelve edge detectors trips process card.
// - Timer counts data duration, flags at end.
// - Timer recycles on gated output word duration.
// - Event card compares word against stored reference.
// - Jumper fitted at reset; group arming by default.
// - Armed card flags completion on data ready.
module cia_top import cia_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NSLOT-1:0][W_DATA-1:0] card_ext_word,
    input wire logic [NSLOT-1:0] card_ext_flag,
    output logic service_request,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Merges a write word into an old value under the byte strobes.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Turns the slot field of an address or data word into a one-hot select.
    function automatic logic [NSLOT-1:0] slot_onehot(input logic [2:0] s);
        logic [NSLOT-1:0] r;
        r = '0;
        for (int i = 0; i < NSLOT; i++) begin
            if (s == 3'(i + 1)) begin
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    localparam int SYW = NSLOT * (W_DATA + 1);

    logic aw_have_q;
    logic w_have_q;
    logic [AW-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [W_MODE-1:0] mode_q;
    logic [W_STAT-1:0] stat_q;
    logic [W_STAT-1:0] mask_q;
    logic [NSLOT-1:0] jumper_q;
    logic [1:0] rel_q;
    logic arm_grp_q;
    logic [NSLOT-1:0] addr_gate_q;
    logic [NSLOT-1:0] data_gate_q;
    logic [W_DATA-1:0] gate_data_q;
    logic [NSLOT-1:0] flag_prev_q;
    logic [SYW-1:0] sy1_q;
    logic [SYW-1:0] sy2_q;
    logic [SYW-1:0] sy3_q;
    logic [SYW-1:0] ext_q;
    logic [7:0] tick_cnt_q;
    logic tick_q;
    logic [NSLOT-1:0] flag_vec;
    logic [15:0] ret_word [NSLOT];

    ////////////////////////////////////////////////////////////////////////////////
    // Write channel handshakes and write decode.
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire b_done = s_axi_bvalid & s_axi_bready;
    wire wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
    wire wr_ctrl = wr_fire & (aw_addr_q == OFF_CTRL);
    wire wr_addr = wr_fire & (aw_addr_q == OFF_ADDR);
    wire wr_data = wr_fire & (aw_addr_q == OFF_DATA);
    wire wr_stat = wr_fire & (aw_addr_q == OFF_STAT);
    wire wr_mask = wr_fire & (aw_addr_q == OFF_MASK);
    wire wr_jmp = wr_fire & (aw_addr_q == OFF_JUMPER);
    wire wr_clr = wr_fire & (aw_addr_q == OFF_SYSCLR);
    wire wr_rel = wr_fire & (aw_addr_q == OFF_REL);
    wire wr_ret = (aw_addr_q[7:4] == OFF_RET[7:4]) & (aw_addr_q[1:0] == 2'h0);
    wire wr_hit = wr_ctrl | wr_addr | wr_data | wr_stat | wr_mask | wr_jmp | wr_clr | wr_rel | (wr_fire & wr_ret);

    // Merged register values and the slot select of gated words.
    wire [31:0] mode_m = merge({23'h000000, mode_q}, w_data_q, w_strb_q);
    wire [31:0] mask_m = merge({27'h0000000, mask_q}, w_data_q, w_strb_q);
    wire [31:0] jmp_m = merge({28'h0000000, jumper_q}, w_data_q, w_strb_q);
    wire [31:0] rel_m = merge({30'h00000000, rel_q}, w_data_q, w_strb_q);
    wire [NSLOT-1:0] wr_sel = slot_onehot(w_data_q[B_SLOT +: 3]);
    wire grp_word = mode_m[B_TIMED] & mode_m[B_ARMEN];

    // Read channel handshakes and read decode.
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire r_done = s_axi_rvalid & s_axi_rready;
    wire [AW-1:0] ra = s_axi_araddr;
    wire ra_ret = (ra[7:4] == OFF_RET[7:4]) & (ra[1:0] == 2'h0);
    wire [1:0] ra_idx = ra[3:2];
    wire ar_flag = flag_vec[ra_idx];
    wire rd_hit = (ra == OFF_CTRL) | (ra == OFF_ADDR) | (ra == OFF_DATA) | (ra == OFF_STAT)
        | (ra == OFF_MASK) | (ra == OFF_JUMPER) | (ra == OFF_SYSCLR) | (ra == OFF_REL) | ra_ret;
    wire [31:0] rd_word = (ra == OFF_CTRL) ? {23'h000000, mode_q} :
        (ra == OFF_STAT) ? {27'h0000000, stat_q} :
        (ra == OFF_MASK) ? {27'h0000000, mask_q} :
        (ra == OFF_JUMPER) ? {28'h0000000, jumper_q} :
        (ra == OFF_REL) ? {30'h00000000, rel_q} :
        ra_ret ? {16'h0000, ret_word[ra_idx]} : 32'h00000000;

    // Service request qualified by mode, and the status events.
    wire mode_int = mode_q[B_ARMEN] & mode_q[B_TIMED] & mode_q[B_SYSEN];
    wire srq_d = mode_int & (|flag_vec);
    wire [W_STAT-1:0] stat_set = {flag_vec & ~flag_prev_q, srq_d & ~service_request};
    wire [W_STAT-1:0] stat_clr = wr_stat ? w_data_q[W_STAT-1:0] : 5'h00;

    // Pin inputs agree over the second and third stages before they count.
    wire [SYW-1:0] sy_agree = ~(sy2_q ^ sy3_q);

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write side: address and data may come in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            aw_have_q <= (aw_have_q | aw_take) & ~b_done;
            w_have_q <= (w_have_q | w_take) & ~b_done;
            s_axi_awready <= ~((aw_have_q | aw_take) & ~b_done);
            s_axi_wready <= ~((w_have_q | w_take) & ~b_done);
            if (aw_take) begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (b_done) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read side: one read at a time, answered the cycle after it is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~((s_axi_rvalid | ar_take) & ~r_done);
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (r_done) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode register, configuration and the one-cycle gate strobes to the cards.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= 9'h000;
            mask_q <= 5'h00;
            jumper_q <= JUMPER_RST;
            rel_q <= 2'h0;
            arm_grp_q <= 1'b0;
            addr_gate_q <= 4'h0;
            data_gate_q <= 4'h0;
            gate_data_q <= 12'h000;
        end else begin
            arm_grp_q <= wr_ctrl & grp_word;
            addr_gate_q <= wr_addr ? wr_sel : 4'h0;
            data_gate_q <= wr_data ? wr_sel : 4'h0;
            if (wr_data) begin
                gate_data_q <= w_data_q[W_DATA-1:0];
            end
            if (wr_clr) begin
                mode_q <= 9'h000;
            end else if (wr_ctrl) begin
                mode_q <= mode_m[W_MODE-1:0];
            end
            if (wr_mask) begin
                mask_q <= mask_m[W_STAT-1:0];
            end
            if (wr_jmp) begin
                jumper_q <= jmp_m[NSLOT-1:0];
            end
            if (wr_rel) begin
                rel_q <= rel_m[1:0];
            end
        end
    end

    // Sticky status, set wins over a write-one clear, and the interrupt line.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_q <= 5'h00;
            flag_prev_q <= 4'h0;
            service_request <= 1'b0;
            irq <= 1'b0;
        end else begin
            stat_q <= (stat_q & ~stat_clr) | stat_set;
            flag_prev_q <= flag_vec;
            service_request <= srq_d;
            irq <= |(stat_q & mask_q);
        end
    end

    // Three-stage pin synchronisers for card words and flags.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sy1_q <= '0;
            sy2_q <= '0;
            sy3_q <= '0;
            ext_q <= '0;
        end else begin
            sy1_q <= {card_ext_flag, card_ext_word};
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
            ext_q <= (ext_q & ~sy_agree) | (sy3_q & sy_agree);
        end
    end

    // Divider giving the timer cards a one-cycle tick each microsecond.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_q <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (tick_cnt_q == 8'(TICK_CYC - 1));
            tick_cnt_q <= (tick_cnt_q == 8'(TICK_CYC - 1)) ? 8'h00 : tick_cnt_q + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One card per slot: digital input, process interrupt, timer, event sense.
    for (genvar i = 0; i < NSLOT; i++) begin : g_slot
        cia_card_if cif();
        assign cif.timed_handshake_enable = mode_q[B_TIMED];
        assign cif.interrupt_arm_enable = mode_q[B_ARMEN];
        assign cif.input_direction_select = mode_q[B_INSEL];
        assign cif.system_output_enable = mode_q[B_SYSEN];
        assign cif.group_arm_jumper = jumper_q[i];
        assign cif.arm_group = arm_grp_q;
        assign cif.addr_gate = addr_gate_q[i];
        assign cif.data_gate = data_gate_q[i];
        assign cif.gate_data = gate_data_q;
        assign cif.relation = rel_q;
        assign cif.ext_word = ext_q[i*W_DATA +: W_DATA];
        assign cif.ext_flag = ext_q[NSLOT*W_DATA + i];
        assign cif.tick = tick_q;
        assign flag_vec[i] = cif.card_completion_flag;
        assign ret_word[i] = {cif.card_completion_flag, 3'h0, cif.held_word};
        cia_card #(
            .CTYPE(cia_ctype_t'(2'(i)))
        ) u_card (
            .aclk(aclk),
            .aresetn(aresetn),
            .cif(cif.card)
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_srq_gate;
        !mode_int |=> !service_request;
    endproperty
    a_srq_gate: assert property (p_srq_gate) else $error("Service request outside interrupt mode.");

    property p_srq_or;
        mode_int && (|flag_vec) |=> service_request;
    endproperty
    a_srq_or: assert property (p_srq_or) else $error("Flag did not raise the service request.");

    property p_srq_cause;
        $rose(service_request) |-> $past(|flag_vec) && $past(mode_int);
    endproperty
    a_srq_cause: assert property (p_srq_cause) else $error("Service request rose without a cause.");

    property p_group_word;
        wr_ctrl && grp_word |=> arm_grp_q ##1 !arm_grp_q;
    endproperty
    a_group_word: assert property (p_group_word) else $error("Group arm strobe wrong.");

    property p_ret_flag;
        ar_take && ra_ret |=> s_axi_rvalid && s_axi_rdata[B_FLAG] == $past(ar_flag);
    endproperty
    a_ret_flag: assert property (p_ret_flag) else $error("Return word flag bit wrong.");

    property p_jumper_reset;
        $rose(aresetn) |-> jumper_q == JUMPER_RST;
    endproperty
    a_jumper_reset: assert property (p_jumper_reset) else $error("Jumpers not fitted after reset.");
endmodule

// [inc/cia_card_if.sv]
`timescale 1ns/10ps
interface cia_card_if;
    import cia_pkg::*;
    logic timed_handshake_enable;
    logic interrupt_arm_enable;
    logic input_direction_select;
    logic system_output_enable;
    logic group_arm_jumper;
    logic arm_group;
    logic addr_gate;
    logic data_gate;
    logic [W_DATA-1:0] gate_data;
    logic [1:0] relation;
    logic [W_DATA-1:0] ext_word;
    logic ext_flag;
    logic tick;
    logic armed;
    logic card_completion_flag;
    logic [W_DATA-1:0] held_word;
    modport ctl(output timed_handshake_enable, interrupt_arm_enable, input_direction_select,
        system_output_enable, group_arm_jumper, arm_group, addr_gate, data_gate, gate_data,
        relation, ext_word, ext_flag, tick, input armed, card_completion_flag, held_word);
    modport card(input timed_handshake_enable, interrupt_arm_enable, input_direction_select,
        system_output_enable, group_arm_jumper, arm_group, addr_gate, data_gate, gate_data,
        relation, ext_word, ext_flag, tick, output armed, card_completion_flag, held_word);
endinterface

// [inc/cia_pkg.sv]
package cia_pkg;
    // Slot count and register map, byte addresses on the AXI4-Lite bus.
    localparam int NSLOT = 4;
    localparam int AW = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ADDR = 8'h04;
    localparam logic [7:0] OFF_DATA = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0C;
    localparam logic [7:0] OFF_MASK = 8'h10;
    localparam logic [7:0] OFF_JUMPER = 8'h14;
    localparam logic [7:0] OFF_SYSCLR = 8'h18;
    localparam logic [7:0] OFF_REL = 8'h1C;
    localparam logic [7:0] OFF_RET = 8'h20;
    // Control word mode bits, as weighted in the octal mode field.
    localparam int B_SYSEN = 5;
    localparam int B_TIMED = 4;
    localparam int B_INSEL = 7;
    localparam int B_ARMEN = 8;
    localparam int W_MODE = 9;
    // Slot field of address and data words, and the card data width.
    localparam int B_SLOT = 12;
    localparam int W_DATA = 12;
    localparam int W_STAT = 5;
    // Flag bit of a return word, weight octal 100000.
    localparam int B_FLAG = 15;
    localparam logic [NSLOT-1:0] JUMPER_RST = 4'hF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Timer cards count in ticks of one microsecond.
    localparam int CLK_NS = 8;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [1:0] {CS_DISARMED = 2'b00, CS_ARMED = 2'b01, CS_FLAGGED = 2'b10} cia_cstate_t;
    typedef enum logic [1:0] {CT_DIGITAL = 2'b00, CT_PROC = 2'b01, CT_TIMER = 2'b10, CT_EVENT = 2'b11} cia_ctype_t;
    typedef enum logic [1:0] {REL_EQ = 2'b00, REL_NE = 2'b01, REL_GT = 2'b10, REL_LT = 2'b11} cia_rel_t;
endpackage
